// >>> shared/fpp_defines.vh
`ifndef FPP_DEFINES_VH
`define FPP_DEFINES_VH

// Register byte offsets
`define FPP_OFS_CTRL 8'h00
`define FPP_OFS_EBS1 8'h04
`define FPP_OFS_EBS2 8'h08
`define FPP_OFS_STAT 8'h0C

// Control register fields
`define FPP_CTRL_PROG 0
`define FPP_CTRL_ERASE 1
`define FPP_CTRL_WCHK 2
`define FPP_CTRL_ECHK 3
`define FPP_CTRL_W 4

// Reset and reserved values
`define FPP_CTRL_RST 4'h0
`define FPP_EBS1_RST 4'h0
`define FPP_EBS2_RST 8'h00
`define FPP_EBS1_RSV 4'hF

// Block counts
`define FPP_LARGE_BLOCKS 4
`define FPP_SMALL_BLOCKS 8
`define FPP_BLOCKS 12

// Status register fields
`define FPP_STAT_HWP 0
`define FPP_STAT_VPP 1
`define FPP_STAT_PROM 2
`define FPP_STAT_PROG 3
`define FPP_STAT_ERASE 4

// Number of synchronised pins, programmer pins included
`define FPP_COND_W 8

// Positions in the synchronised condition vector
`define FPP_COND_VPP 0
`define FPP_COND_LOWP_LO 1
`define FPP_COND_LOWP_HI 5
`define FPP_COND_PROM 6
`define FPP_COND_PREQ 7

// Width of the byte-wide block select read field
`define FPP_EBS_RD_W 8

`endif

// >>> rtl/fpp_sync.v
`timescale 1ns/1ps
`default_nettype none

module fpp_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire ref_clk,
	input wire arst_n,
	// Asynchronous levels in, synchronised levels out
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	// First stage, read only by the second stage
	reg [WIDTH-1:0] meta;

	////////////////////////////////////////////////////////////////////////
	// Two flip-flop level synchroniser
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule // fpp_sync

`default_nettype wire

// >>> rtl/fpp_protect.v
// Function
// - Software protection stops program and erase entry
// - Per-block select; verify stays usable
// - First F0 second 00 protects all
// - Hardware protection aborts and clears registers
// - No 12 V: registers cleared, all disabled
// - Reset, low-power modes clear and block
// - Hardware protection erase-disables every block
// - Three verify modes are gated
// - External programmer mode programs freely
`timescale 1ns/1ps
`default_nettype none
`include "fpp_defines.vh"

module fpp_protect (
	// Clock and reset
	input wire ref_clk,
	input wire arst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Protection condition pins, asynchronous
	input wire high_voltage_supply_pin,
	input wire wdt_reset,
	input wire sleep_mode,
	input wire subsleep_mode,
	input wire watch_mode,
	input wire standby_mode,
	// External programmer mode and its requests, asynchronous
	input wire prom_mode,
	input wire prom_prog_req,
	// Sequencer side: block addressed by the current program access
	input wire [3:0] target_block,
	// Sequencer enables
	output reg prog_en,
	output reg erase_en,
	output reg [`FPP_BLOCKS-1:0] block_erase_en,
	output reg write_check_en,
	output reg wipe_check_en,
	output reg prewrite_check_en,
	output reg hw_protect
);

	// Raw and synchronised condition pins
	wire [`FPP_COND_W-1:0] cond_raw;
	wire [`FPP_COND_W-1:0] cond_s;
	// Registers
	reg [`FPP_CTRL_W-1:0] flash_control_reg;
	reg [`FPP_LARGE_BLOCKS-1:0] erase_block_select_first;
	reg [`FPP_SMALL_BLOCKS-1:0] erase_block_select_second;
	// Decoded conditions
	wire vpp_ok;
	wire prom_s;
	wire prom_req_s;
	wire hw_now;
	wire wr_take;
	wire rd_start;
	wire [`FPP_BLOCKS-1:0] blk_sel;
	wire tgt_sel;
	// Next values of the enables
	reg next_prog_en;
	reg next_erase_en;
	reg [`FPP_BLOCKS-1:0] next_block_erase_en;
	reg next_write_check;
	reg next_wipe_check;
	reg next_prewrite_check;
	reg [31:0] next_prdata;
	reg next_pslverr;

	////////////////////////////////////////////////////////////////////////
	// Address decode, used for both reads and writes
	function addr_mapped;
		input [7:0] a;
		begin
			addr_mapped = (a == `FPP_OFS_CTRL) || (a == `FPP_OFS_EBS1) ||
				(a == `FPP_OFS_EBS2) || (a == `FPP_OFS_STAT);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	assign cond_raw = {prom_prog_req, prom_mode, standby_mode, watch_mode,
		subsleep_mode, sleep_mode, wdt_reset, high_voltage_supply_pin};

	fpp_sync #(
		.WIDTH(`FPP_COND_W)
	) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.async_in(cond_raw),
		.sync_out(cond_s)
	);

	assign vpp_ok = cond_s[`FPP_COND_VPP];
	assign prom_s = cond_s[`FPP_COND_PROM];
	assign prom_req_s = cond_s[`FPP_COND_PREQ];

	// Hardware protection sources
	// Missing 12 V, watchdog reset or any low-power mode
	assign hw_now = ~vpp_ok |
		(|cond_s[`FPP_COND_LOWP_HI:`FPP_COND_LOWP_LO]);

	// Block select vector: small blocks low, large blocks high
	// Selected blocks only
	// A clear bit protects its block, so F0 and 00 protect everything
	assign blk_sel = {erase_block_select_first, erase_block_select_second};
	assign tgt_sel = (target_block < `FPP_BLOCKS) ?
		blk_sel[target_block] : 1'b0;

	// APB strobes: write lands on the edge that samples pready high
	assign wr_take = psel & penable & pready & pwrite;
	assign rd_start = psel & penable & ~pready;

	////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, then pready for one cycle
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= rd_start;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// Read mux and error answer, latched as pready rises
	always @* begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (rd_start) begin
			// Unmapped offsets answer with an error and zero data
			next_pslverr = ~addr_mapped(paddr);
			if (!pwrite) begin
				case (paddr)
					`FPP_OFS_CTRL: begin
						next_prdata[`FPP_CTRL_W-1:0] = flash_control_reg;
					end
					`FPP_OFS_EBS1: begin
						// Upper reserved bits read as one
						next_prdata[`FPP_EBS_RD_W-1:0] = {`FPP_EBS1_RSV,
							erase_block_select_first};
					end
					`FPP_OFS_EBS2: begin
						next_prdata[`FPP_EBS_RD_W-1:0] =
							erase_block_select_second;
					end
					`FPP_OFS_STAT: begin
						next_prdata[`FPP_STAT_HWP] = hw_protect;
						next_prdata[`FPP_STAT_VPP] = vpp_ok;
						next_prdata[`FPP_STAT_PROM] = prom_s;
						next_prdata[`FPP_STAT_PROG] = prog_en;
						next_prdata[`FPP_STAT_ERASE] = erase_en;
					end
					default: begin
						next_prdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file
	// Reset length is the system's duty; arst_n clears at once
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flash_control_reg <= `FPP_CTRL_RST;
			erase_block_select_first <= `FPP_EBS1_RST;
			erase_block_select_second <= `FPP_EBS2_RST;
		end else if (hw_now) begin
			// Clear on detection
			// Writes are ignored while the condition lasts
			flash_control_reg <= `FPP_CTRL_RST;
			erase_block_select_first <= `FPP_EBS1_RST;
			erase_block_select_second <= `FPP_EBS2_RST;
		end else if (wr_take) begin
			case (paddr)
				`FPP_OFS_CTRL: begin
					flash_control_reg <= pwdata[`FPP_CTRL_W-1:0];
				end
				`FPP_OFS_EBS1: begin
					erase_block_select_first <=
						pwdata[`FPP_LARGE_BLOCKS-1:0];
				end
				`FPP_OFS_EBS2: begin
					erase_block_select_second <=
						pwdata[`FPP_SMALL_BLOCKS-1:0];
				end
				default: begin
					// Status and unmapped offsets store nothing
					flash_control_reg <= flash_control_reg;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Enable decode toward the program/erase sequencer
	// Interrupt masking while these are set is left to software
	always @* begin
		next_prog_en = 1'b0;
		next_erase_en = 1'b0;
		next_block_erase_en = {`FPP_BLOCKS{1'b0}};
		next_write_check = 1'b0;
		next_wipe_check = 1'b0;
		next_prewrite_check = 1'b0;
		if (hw_now) begin
			// Verify modes are blocked as well
			next_prog_en = 1'b0;
		end else if (prom_s) begin
			next_prog_en = prom_req_s;
		end else begin
			// Program only into a selected block
			next_prog_en = flash_control_reg[`FPP_CTRL_PROG] & tgt_sel;
			next_block_erase_en = flash_control_reg[`FPP_CTRL_ERASE] ?
				blk_sel : {`FPP_BLOCKS{1'b0}};
			next_erase_en = |next_block_erase_en;
			next_write_check = flash_control_reg[`FPP_CTRL_WCHK];
			next_wipe_check = flash_control_reg[`FPP_CTRL_ECHK];
			// Prewrite-verify is all bits clear; wait is software's
			next_prewrite_check = (flash_control_reg == `FPP_CTRL_RST);
		end
	end

	// Registered enables
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prog_en <= 1'b0;
			erase_en <= 1'b0;
			block_erase_en <= {`FPP_BLOCKS{1'b0}};
			write_check_en <= 1'b0;
			wipe_check_en <= 1'b0;
			prewrite_check_en <= 1'b0;
			hw_protect <= 1'b1;
		end else begin
			prog_en <= next_prog_en;
			erase_en <= next_erase_en;
			block_erase_en <= next_block_erase_en;
			write_check_en <= next_write_check;
			wipe_check_en <= next_wipe_check;
			prewrite_check_en <= next_prewrite_check;
			hw_protect <= hw_now;
		end
	end

endmodule // fpp_protect

`default_nettype wire

// >>> bench/fpp_protect_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpp_defines.vh"
// Port-level checks of the protect block
module fpp_protect_props (
	// Clock, reset and APB
	input wire logic ref_clk, arst_n, psel, penable, pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic pready, pslverr,
	// Condition pins and block index
	input wire logic high_voltage_supply_pin, wdt_reset, sleep_mode,
	input wire logic subsleep_mode, watch_mode, standby_mode,
	input wire logic prom_mode, prom_prog_req,
	input wire logic [3:0] target_block,
	// Sequencer enables
	input wire logic prog_en, erase_en, write_check_en, wipe_check_en,
	input wire logic [`FPP_BLOCKS-1:0] block_erase_en,
	input wire logic prewrite_check_en, hw_protect
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Any low-power or watchdog condition
	wire logic lowp = wdt_reset | sleep_mode | subsleep_mode | watch_mode
		| standby_mode;
	// Offset is one of the four register words
	wire logic mapped = (paddr == `FPP_OFS_CTRL) || (paddr == `FPP_OFS_EBS1)
		|| (paddr == `FPP_OFS_EBS2) || (paddr == `FPP_OFS_STAT);
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_hw_blocks_all: assert property (hw_protect |-> !prog_en && !erase_en
		&& !block_erase_en && !write_check_en && !wipe_check_en
		&& !prewrite_check_en) else $error("enable under protection");
	a_erase_or: assert property (erase_en == (|block_erase_en))
		else $error("erase enable mismatch");
	a_vpp_protect: assert property (!high_voltage_supply_pin [*4]
		|-> hw_protect) else $error("no protect without vpp");
	a_lowpower_protect: assert property (lowp [*4] |-> hw_protect)
		else $error("no protect in low power");
	a_unmapped_err: assert property (pready && !mapped
		|-> pslverr && prdata == 0) else $error("unmapped not refused");
	a_mapped_ok: assert property (pready && mapped |-> !pslverr)
		else $error("mapped refused");
	a_prom_prog: assert property ((prom_mode && prom_prog_req && !lowp
		&& high_voltage_supply_pin) [*4] |-> prog_en)
		else $error("programmer request lost");
	cover property (pready && pwrite);
	cover property ($fell(hw_protect));
	cover property (erase_en);
endmodule // fpp_protect_props
`default_nettype wire

// >>> bench/fpp_cpu.sv
`timescale 1ns/1ps
`default_nettype none
// CPU-side APB master issuing register accesses
module fpp_cpu (
	// Clock
	input wire logic ref_clk,
	// APB request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	// APB answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Bus idle at time zero
	initial {psel, penable, pwrite, paddr, pwdata} = 0;
	// No interrupts raised
	// One transfer; released lines show inverted garbage
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		paddr <= ~a;
		pwdata <= ~wd;
	endtask
endmodule // fpp_cpu
`default_nettype wire

// >>> bench/test_flash_program_erase_protect.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_erase_protect;
	// Stimulus and bookkeeping
	logic ref_clk = 0, arst_n = 0, prom_mode = 0, prom_prog_req = 0, e;
	logic [5:0] cond = 0;
	logic [3:0] target_block = 0, c, e1, tb;
	logic [7:0] e2;
	logic [31:0] d;
	logic [16:0] x;
	int err_total = 0, n_checks = 0, i;
	wire logic psel, penable, pwrite, pready, pslverr, prog_en, erase_en;
	wire logic write_check_en, wipe_check_en, prewrite_check_en, hw_protect;
	wire logic [7:0] paddr;
	wire logic [31:0] pwdata, prdata;
	wire logic [11:0] block_erase_en;
	wire logic [16:0] en_bus = {prog_en, erase_en, block_erase_en,
		write_check_en, wipe_check_en, prewrite_check_en};
	fpp_protect dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.high_voltage_supply_pin(~cond[0]), .wdt_reset(cond[1]),
		.sleep_mode(cond[2]), .subsleep_mode(cond[3]), .watch_mode(cond[4]),
		.standby_mode(cond[5]), .prom_mode(prom_mode),
		.prom_prog_req(prom_prog_req), .target_block(target_block),
		.prog_en(prog_en), .erase_en(erase_en),
		.block_erase_en(block_erase_en), .write_check_en(write_check_en),
		.wipe_check_en(wipe_check_en), .prewrite_check_en(prewrite_check_en),
		.hw_protect(hw_protect));
	fpp_cpu cpu_u (.ref_clk(ref_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	initial forever #50 ref_clk = ~ref_clk;
	// Expected enables from register contents and target block
	function automatic [16:0] exp_en(input [3:0] c, input [3:0] e1,
		input [7:0] e2, input [3:0] tb);
		logic [11:0] m;
		m = {e1, e2};
		return {c[0] & (tb < 12 && m[tb]), c[1] & (|m), c[1] ? m : 12'h000,
			c[2], c[3], c == 0};
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rdc(input [7:0] a, input [31:0] exp, input er);
		cpu_u.xfer(0, a, 0, d, e);
		chk(d, exp);
		chk(e, er);
	endtask
	task setregs;
		cpu_u.xfer(1, 8'h04, {4'hF, e1}, d, e);
		cpu_u.xfer(1, 8'h08, e2, d, e);
		cpu_u.xfer(1, 8'h00, c, d, e);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task test_done;
		if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#3_000_000;
		err_total++;
		test_done;
	end
	///////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(94978));
		repeat (3) @(posedge ref_clk);
		arst_n <= 1;
		repeat (6) @(posedge ref_clk);
		rdc(8'h00, 0, 0);
		rdc(8'h04, 32'h0000_00F0, 0);
		rdc(8'h08, 0, 0);
		rdc(8'h0C, 32'h0000_0002, 0);
		rdc(8'h10, 0, 1);
		// Random settings, first ones with every block protected
		for (i = 0; i < 40; i++) begin
			c = $urandom;
			{e1, e2} = (i < 4) ? 12'h000 : 12'($urandom);
			tb = $urandom;
			target_block <= tb;
			setregs;
			x = exp_en(c, e1, e2, tb);
			chk(en_bus, x);
			if (c == 0) repeat (40) @(posedge ref_clk);
			rdc(8'h0C, {27'h0, x[15], x[16], 3'b010}, 0);
		end
		// Each hardware condition clears and blocks
		for (i = 0; i < 6; i++) begin
			{c, e1, e2} = 16'h3F_FF;
			setregs;
			cond <= 6'b1 << i;
			repeat (4) @(posedge ref_clk);
			cpu_u.xfer(1, 8'h00, 1, d, e);
			#1 chk({hw_protect, en_bus}, 32'h0002_0000);
			rdc(8'h0C, (i == 0) ? 32'h0000_0001 : 32'h0000_0003, 0);
			@(posedge ref_clk) cond <= 0;
			repeat (5) @(posedge ref_clk);
			rdc(8'h00, 0, 0);
			rdc(8'h04, 32'h0000_00F0, 0);
			rdc(8'h08, 0, 0);
		end
		// Mid-run reset held eleven clocks
		setregs;
		@(posedge ref_clk) arst_n <= 0;
		repeat (10) @(posedge ref_clk);
		#1 chk({hw_protect, en_bus}, 32'h0002_0000);
		@(posedge ref_clk) arst_n <= 1;
		repeat (6) @(posedge ref_clk);
		rdc(8'h00, 0, 0);
		// External programmer requests
		prom_mode <= 1;
		for (i = 0; i < 2; i++) begin
			@(posedge ref_clk) prom_prog_req <= i[0];
			repeat (5) @(posedge ref_clk);
			#1 chk({prog_en, erase_en}, {i[0], 1'b0});
		end
		rdc(8'h0C, 32'h0000_000E, 0);
		test_done;
	end
endmodule // test_flash_program_erase_protect
bind fpp_protect fpp_protect_props chk_u (.*);
`default_nettype wire
